// ===== pkg/sbrx_pkg.sv
/*
  Shared constants and types for the single-wire brightness link:
  timing of the line, code width, reset values and the host's register map.
  Assumes one 40 MHz core clock on both ends.
*/
package sbrx_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ            = 40;
  localparam int LOW_PHASE_MIN_NS   = 500;
  localparam int HIGH_PHASE_MIN_NS  = 500;
  localparam int PHASE_MAX_US       = 40;
  localparam int BIT_PERIOD_MIN_US  = 2;
  localparam int BIT_PERIOD_MAX_US  = 53;
  localparam int IDLE_CLEAR_TIME_US = 100;
  // Least times round up
  localparam int LOW_PHASE_MIN_CYC  = (LOW_PHASE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CLEAR_CYC     = IDLE_CLEAR_TIME_US * CLK_MHZ;
  localparam int CNT_W              = 13;

  // ----------------------------------------------------------------
  // Code word
  // ----------------------------------------------------------------
  localparam int CODE_W             = 5;
  localparam int BITCNT_W           = 3;
  localparam logic [BITCNT_W-1:0] CODE_BITS = 3'h5;
  localparam logic [CODE_W-1:0] CODE_RESET  = 5'h1F;
  localparam logic [CODE_W-1:0] CODE_ZERO   = 5'h00;
  localparam int LEVELS             = 32;

  // ----------------------------------------------------------------
  // Host registers (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_TIMING  = 12'h004;
  localparam logic [11:0] ADDR_STATUS  = 12'h008;
  localparam int CTRL_CODE_LSB         = 0;
  localparam int CTRL_GO_BIT           = 8;
  localparam int CTRL_EN_BIT           = 9;
  localparam int CTRL_EXTRA_LSB        = 12;
  localparam int STAT_BUSY_BIT         = 0;
  localparam logic [15:0] TIM_SHORT_RESET = 16'h0028;
  localparam logic [15:0] TIM_LONG_RESET  = 16'h0078;

  typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_STOP, HS_GAP} sbrx_hstate_t;

endpackage : sbrx_pkg

// ===== pkg/sbrx_if.sv
/*
  Carrier of the single data wire and the turn-on pin between the host end
  and the receiving device. Host drives both; the device drives nothing.
*/
interface sbrx_if;
  logic data_line;
  logic turn_on;
  modport host_mp (output data_line, output turn_on);
  modport dev_mp  (input  data_line, input  turn_on);
endinterface : sbrx_if

// ===== rtl/sbrx_device.sv
/*
  Receiving device end: decodes duty-ratio bits on the data line, holds the
  brightness code and derives the power-on request and drive level.
  Assumes the data line is synchronous to CORE_CLK_I and idles high.
*/
module sbrx_device
  import sbrx_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              ARST_N_I,
  // Link
  sbrx_if.dev_mp                 link,
  // Thermal indications
  input  wire logic              OVER_TEMP_I,
  input  wire logic              COOLED_I,
  // Device state
  output logic [CODE_W-1:0]      BRIGHTNESS_CODE_O,
  output logic [CODE_W:0]        LED_DRIVE_CURRENT_O,
  output logic                   POWER_ON_REQUEST_O,
  output logic                   THERMAL_HOLD_O
);

  // ----------------------------------------------------------------
  // Thermal hold, acts as an internal reset
  // ----------------------------------------------------------------
  logic thermal_reg;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      thermal_reg <= 1'b0;
    else if (OVER_TEMP_I)
      thermal_reg <= 1'b1;
    else if (COOLED_I)
      thermal_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Line sampling and edges
  // ----------------------------------------------------------------
  logic data_reg;
  logic ton_reg;
  logic fall;
  logic rise;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      data_reg <= 1'b1;
      ton_reg  <= 1'b0;
    end
    else
    begin
      data_reg <= link.data_line;
      ton_reg  <= link.turn_on;
    end
  end

  assign fall = data_reg && !link.data_line;
  assign rise = !data_reg && link.data_line;

  // ----------------------------------------------------------------
  // Phase counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] high_cnt_reg;
  logic             idle_clear;

  assign idle_clear = (high_cnt_reg >= CNT_W'(IDLE_CLEAR_CYC));

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
    end
    else if (fall)
    begin
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
    end
    else if (!data_reg)
    begin
      if (low_cnt_reg != '1)
        low_cnt_reg <= low_cnt_reg + 1'b1;
    end
    else if (high_cnt_reg != '1)
      high_cnt_reg <= high_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------------
  // Bit decoding and word assembly
  // ----------------------------------------------------------------
  logic                in_word_reg;
  logic [BITCNT_W-1:0] bit_cnt_reg;
  logic [CODE_W-1:0]   shift_reg;
  logic                bit_val;

  // High count lacks the closing cycle, so a tie means high was longer
  assign bit_val = (high_cnt_reg >= low_cnt_reg);

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      in_word_reg <= 1'b0;
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end
    else if (thermal_reg)
    begin
      in_word_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end
    else if (data_reg && idle_clear && !fall)
    begin
      in_word_reg <= 1'b0;
      bit_cnt_reg <= '0;
    end
    else if (fall)
    begin
      in_word_reg <= 1'b1;
      // Fall after a long idle opens a fresh word
      if (idle_clear)
        bit_cnt_reg <= '0;
      else if (in_word_reg && bit_cnt_reg < CODE_BITS)
      begin
        shift_reg   <= {bit_val, shift_reg[CODE_W-1:1]};
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Brightness register and power request
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] code_reg;
  logic              latched_reg;
  logic              pwr_reg;
  logic              take;

  // Rising edge after the fifth bit: stop pulse or sixth bit
  assign take = rise && in_word_reg && (bit_cnt_reg == CODE_BITS)
                && !latched_reg;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      code_reg    <= CODE_RESET;
      latched_reg <= 1'b0;
      pwr_reg     <= 1'b0;
    end
    else if (thermal_reg)
    begin
      code_reg    <= CODE_RESET;
      latched_reg <= 1'b0;
      pwr_reg     <= 1'b0;
    end
    else
    begin
      if (!in_word_reg || idle_clear)
        latched_reg <= 1'b0;
      else if (take)
        latched_reg <= 1'b1;
      if (take)
        code_reg <= shift_reg;
      if (!ton_reg && link.turn_on)
        pwr_reg <= 1'b1;
      else if (ton_reg && !link.turn_on)
        pwr_reg <= 1'b0;
      else if (take)
        pwr_reg <= (shift_reg != CODE_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Outputs; drive is in thirty-seconds of full scale
  // ----------------------------------------------------------------
  assign BRIGHTNESS_CODE_O   = code_reg;
  assign POWER_ON_REQUEST_O  = pwr_reg;
  assign THERMAL_HOLD_O      = thermal_reg;
  assign LED_DRIVE_CURRENT_O = (!pwr_reg || code_reg == CODE_ZERO) ? '0
                             : {1'b0, code_reg} + 1'b1;

endmodule : sbrx_device

// ===== rtl/sbrx_host.sv
/*
  Host end: an APB slave whose registers order one brightness word on the
  data line, with selectable phase timing, plus the turn-on pin.
  Assumes APB synchronous to CORE_CLK_I.
*/
// Design decisions made here: the APB register port and the placing of the registers.
module sbrx_host
  import sbrx_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        ARST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Link
  sbrx_if.host_mp          link
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] code_reg;
  logic              en_reg;
  logic [2:0]        extra_reg;
  logic [15:0]       short_reg;
  logic [15:0]       long_reg;
  logic [31:0]       rdata_reg;
  logic              busy;
  logic              wr;
  logic              go;
  logic              hit;

  assign wr  = PSEL_I && PENABLE_I && PWRITE_I;
  assign hit = (PADDR_I == ADDR_CTRL) || (PADDR_I == ADDR_TIMING)
            || (PADDR_I == ADDR_STATUS);
  assign go  = wr && (PADDR_I == ADDR_CTRL) && PWDATA_I[CTRL_GO_BIT] && !busy;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;
  assign PRDATA_O  = rdata_reg;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      code_reg  <= CODE_RESET;
      en_reg    <= 1'b0;
      extra_reg <= '0;
      short_reg <= TIM_SHORT_RESET;
      long_reg  <= TIM_LONG_RESET;
    end
    else if (wr && PADDR_I == ADDR_CTRL)
    begin
      en_reg    <= PWDATA_I[CTRL_EN_BIT];
      if (!busy)
      begin
        code_reg  <= PWDATA_I[CTRL_CODE_LSB +: CODE_W];
        extra_reg <= PWDATA_I[CTRL_EXTRA_LSB +: 3];
      end
    end
    else if (wr && PADDR_I == ADDR_TIMING && !busy)
    begin
      short_reg <= PWDATA_I[15:0];
      long_reg  <= PWDATA_I[31:16];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
      rdata_reg <= '0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      case (PADDR_I)
        ADDR_CTRL:   rdata_reg <= {16'h0000, 1'b0, extra_reg, 2'h0, en_reg,
                                   1'b0, 3'h0, code_reg};
        ADDR_TIMING: rdata_reg <= {long_reg, short_reg};
        ADDR_STATUS: rdata_reg <= {31'h00000000, busy};
        default:     rdata_reg <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line sequencer: low/high per bit, stop pulse, idle gap
  // ----------------------------------------------------------------
  sbrx_hstate_t      st_reg;
  logic [15:0]       tcnt_reg;
  logic [3:0]        nbit_reg;
  logic [7:0]        sh_reg;
  logic [3:0]        total;
  logic [15:0]       lowt;
  logic [15:0]       hight;

  assign busy  = (st_reg != HS_IDLE);
  assign total = 4'(CODE_BITS) + {1'b0, extra_reg};
  assign lowt  = sh_reg[0] ? short_reg : long_reg;
  assign hight = sh_reg[0] ? long_reg : short_reg;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      st_reg   <= HS_IDLE;
      tcnt_reg <= '0;
      nbit_reg <= '0;
      sh_reg   <= '0;
    end
    else
    begin
      case (st_reg)
        HS_IDLE:
          if (go)
          begin
            sh_reg   <= {PWDATA_I[CTRL_EXTRA_LSB +: 3],
                         PWDATA_I[CTRL_CODE_LSB +: CODE_W]};
            nbit_reg <= '0;
            tcnt_reg <= '0;
            st_reg   <= HS_LOW;
          end
        HS_LOW:
          if (tcnt_reg + 16'h0001 >= lowt)
          begin
            tcnt_reg <= '0;
            st_reg   <= HS_HIGH;
          end
          else
            tcnt_reg <= tcnt_reg + 16'h0001;
        HS_HIGH:
          if (tcnt_reg + 16'h0001 >= hight)
          begin
            tcnt_reg <= '0;
            sh_reg   <= {1'b0, sh_reg[7:1]};
            nbit_reg <= nbit_reg + 4'h1;
            st_reg   <= (nbit_reg + 4'h1 >= total) ? HS_STOP : HS_LOW;
          end
          else
            tcnt_reg <= tcnt_reg + 16'h0001;
        HS_STOP:
          if (tcnt_reg + 16'h0001 >= short_reg)
          begin
            tcnt_reg <= '0;
            st_reg   <= HS_GAP;
          end
          else
            tcnt_reg <= tcnt_reg + 16'h0001;
        HS_GAP:
          if (tcnt_reg >= 16'(IDLE_CLEAR_CYC))
            st_reg <= HS_IDLE;
          else
            tcnt_reg <= tcnt_reg + 16'h0001;
        default:
          st_reg <= HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      link.data_line <= 1'b1;
      link.turn_on   <= 1'b0;
    end
    else
    begin
      link.turn_on   <= en_reg;
      link.data_line <= !((st_reg == HS_IDLE && go) ||
                          (st_reg == HS_LOW && tcnt_reg + 16'h0001 < lowt) ||
                          (st_reg == HS_HIGH && tcnt_reg + 16'h0001 >= hight)
                          || (st_reg == HS_STOP
                              && tcnt_reg + 16'h0001 < short_reg));
    end
  end

endmodule : sbrx_host

// ===== test/sbrx_link_sva.sv
/*
  Checker for the brightness link: wire timing, code latching, drive level,
  power request and thermal hold.
  Assumes one core clock and the active-low reset of both ends.
*/
module sbrx_link_sva
  import sbrx_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              ARST_N_I,
  // Link wires
  input  wire logic              data_line,
  input  wire logic              turn_on,
  // Device pins
  input  wire logic              OVER_TEMP_I,
  input  wire logic              COOLED_I,
  input  wire logic [CODE_W-1:0] BRIGHTNESS_CODE_O,
  input  wire logic [CODE_W:0]   LED_DRIVE_CURRENT_O,
  input  wire logic              POWER_ON_REQUEST_O,
  input  wire logic              THERMAL_HOLD_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic             prev_reg;
  logic [CNT_W-1:0] lvl_reg;
  logic [CNT_W-1:0] per_reg;

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  // ----------------------------------------------------------------
  // Cycles at the present level and since the last fall
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      prev_reg <= 1'b1;
      lvl_reg  <= '1;
      per_reg  <= '1;
    end
    else
    begin
      prev_reg <= data_line;
      if (data_line != prev_reg)
        lvl_reg <= 13'h0001;
      else if (lvl_reg != '1)
        lvl_reg <= lvl_reg + 13'h0001;
      if (!data_line && prev_reg)
        per_reg <= 13'h0001;
      else if (per_reg != '1)
        per_reg <= per_reg + 13'h0001;
    end
  end

  sequence s_fall;
    data_line ##1 !data_line;
  endsequence
  sequence s_rise;
    !data_line ##1 data_line;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_low_phase_len: assert property (
    s_rise |-> lvl_reg >= LOW_PHASE_MIN_CYC && lvl_reg <= 1600)
    else $error("low phase out of range");
  a_high_phase_len: assert property (
    s_fall |-> lvl_reg >= IDLE_CLEAR_CYC || (lvl_reg >= 20 && lvl_reg <= 1600))
    else $error("high phase out of range");
  a_bit_period_len: assert property (
    s_fall |-> lvl_reg >= IDLE_CLEAR_CYC || (per_reg >= 80 && per_reg <= 2120))
    else $error("bit period out of range");
  a_code_on_rise: assert property (
    $changed(BRIGHTNESS_CODE_O) && !$past(OVER_TEMP_I) && !THERMAL_HOLD_O
    && !$past(THERMAL_HOLD_O) |-> data_line && lvl_reg <= 13'h0004)
    else $error("code changed away from a rising edge");
  a_drive_level: assert property (
    LED_DRIVE_CURRENT_O == ((POWER_ON_REQUEST_O && BRIGHTNESS_CODE_O != 5'h00)
    ? {1'b0, BRIGHTNESS_CODE_O} + 6'h01 : 6'h00))
    else $error("drive level wrong");
  a_hold_on_hot: assert property (
    OVER_TEMP_I |=> THERMAL_HOLD_O) else $error("hold not set");
  a_hold_until_cool: assert property (
    THERMAL_HOLD_O && !COOLED_I |=> THERMAL_HOLD_O)
    else $error("hold left early");
  a_hold_restart: assert property (
    THERMAL_HOLD_O && $past(THERMAL_HOLD_O) |->
    BRIGHTNESS_CODE_O == CODE_RESET && !POWER_ON_REQUEST_O)
    else $error("state not reset during hold");
  a_req_pin_rise: assert property (
    $rose(turn_on) && !OVER_TEMP_I && !THERMAL_HOLD_O |-> ##[1:3]
    POWER_ON_REQUEST_O) else $error("request missing after pin rise");
  a_req_pin_fall: assert property (
    $fell(turn_on) |-> ##[1:3] !POWER_ON_REQUEST_O)
    else $error("request stayed after pin fall");
endmodule : sbrx_link_sva

// ===== test/single_wire_brightness_rx_test.sv
/*
  Bench: APB host end driving the device end, and a bench-driven wire into
  a second device for broken words. Assumes the 40 MHz core clock.
*/
module single_wire_brightness_rx_test
  import sbrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [4:0] code;
    logic [2:0] extra;
    logic [5:0] drive;
  } sbrx_row_t;

  logic              clk;
  logic              arst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              over_temp;
  logic              cooled;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] code2;
  logic [CODE_W:0]   drive;
  logic              req;
  logic              hold;
  logic [31:0]       rd_q;
  logic              err_q;
  logic [7:0]        m_bits = 8'h00;
  logic              m_prev = 1'b1;
  int                m_cnt = 0;
  int                m_lo = 0;
  int                m_n = 0;
  int                num_errors = 0;
  int                checked = 0;
  sbrx_row_t         rows [7] = '{'{5'h0A, 3'h0, 6'h0B},
    '{5'h15, 3'h0, 6'h16}, '{5'h00, 3'h0, 6'h00}, '{5'h01, 3'h0, 6'h02},
    '{5'h1F, 3'h1, 6'h20}, '{5'h10, 3'h2, 6'h11}, '{5'h0E, 3'h3, 6'h0F}};

  sbrx_if link ();
  sbrx_if link2 ();

  sbrx_host i_sbrx_host (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .link(link));
  sbrx_device i_sbrx_device (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .link(link),
    .OVER_TEMP_I(over_temp), .COOLED_I(cooled), .BRIGHTNESS_CODE_O(code),
    .LED_DRIVE_CURRENT_O(drive), .POWER_ON_REQUEST_O(req),
    .THERMAL_HOLD_O(hold));
  sbrx_device i_sbrx_device_b (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .link(link2),
    .OVER_TEMP_I(1'b0), .COOLED_I(1'b0), .BRIGHTNESS_CODE_O(code2),
    .LED_DRIVE_CURRENT_O(), .POWER_ON_REQUEST_O(), .THERMAL_HOLD_O());
  sbrx_link_sva i_sbrx_link_sva (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .data_line(link.data_line),
    .turn_on(link.turn_on), .OVER_TEMP_I(over_temp), .COOLED_I(cooled),
    .BRIGHTNESS_CODE_O(code), .LED_DRIVE_CURRENT_O(drive),
    .POWER_ON_REQUEST_O(req), .THERMAL_HOLD_O(hold));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Decodes the wire on its own: bit value at each closing fall
  always @(posedge clk)
  begin
    if (!arst_n)
    begin
      m_prev <= 1'b1;
      m_cnt <= IDLE_CLEAR_CYC;
    end
    else
    begin
      m_prev <= link.data_line;
      m_cnt <= (link.data_line === m_prev) ? m_cnt + 1 : 1;
      if (link.data_line && !m_prev)
        m_lo <= m_cnt;
      if (!link.data_line && m_prev && m_cnt < IDLE_CLEAR_CYC)
      begin
        m_bits <= {m_cnt > m_lo, m_bits[7:1]};
        m_n <= m_n + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_idle;
    rd_q = '1;
    for (int k = 0; k < 3000 && rd_q[STAT_BUSY_BIT] !== 1'b0; k++)
      apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd_q[STAT_BUSY_BIT], 1'b0);
  endtask : wait_idle

  task automatic send(input logic [31:0] ctrl);
    m_n <= 0;
    apb(1'b1, ADDR_CTRL, ctrl | (32'h1 << CTRL_GO_BIT));
    wait_idle();
  endtask : send

  task automatic bit2(input int lo, input int hi);
    link2.data_line <= 1'b0;
    repeat (lo) @(posedge clk);
    link2.data_line <= 1'b1;
    repeat (hi) @(posedge clk);
  endtask : bit2

  initial
  begin
    repeat (80000) @(posedge clk);
    num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, psel, penable, pwrite, over_temp, cooled} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    link2.data_line = 1'b1;
    link2.turn_on = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      send({17'h0, rows[i].extra, 7'h0, rows[i].code});
      check(code, rows[i].code);
      check(drive, rows[i].drive);
      check(req, rows[i].code != 5'h00);
      check(m_n, 5 + rows[i].extra);
      check(m_bits[7 - rows[i].extra -: 5], rows[i].code);
      $display("row %0d done", i);
    end
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check(code, CODE_RESET);
    check({req, drive, link.data_line}, 8'h01);
    apb(1'b0, ADDR_TIMING, 32'h0);
    check(rd_q, {TIM_LONG_RESET, TIM_SHORT_RESET});
    apb(1'b0, 12'h00C, 32'h0);
    check(err_q, 1'b1);
    check(rd_q, 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EN_BIT);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd_q, 32'h0000_0200);
    repeat (5) @(posedge clk);
    check({req, drive}, 7'h60);
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (5) @(posedge clk);
    check(req, 1'b0);
    $display("reset and pin test done");
    apb(1'b1, ADDR_TIMING, 32'h003C_0014);
    send(32'h13);
    check(code, 5'h13);
    apb(1'b1, ADDR_CTRL, 32'h105);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd_q[STAT_BUSY_BIT], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h11A);
    wait_idle();
    check(code, 5'h05);
    $display("timing and busy test done");
    over_temp <= 1'b1;
    repeat (3) @(posedge clk);
    over_temp <= 1'b0;
    repeat (3) @(posedge clk);
    check({hold, code, req}, 7'h7E);
    cooled <= 1'b1;
    repeat (3) @(posedge clk);
    cooled <= 1'b0;
    check(hold, 1'b0);
    $display("thermal test done");
    repeat (3) bit2(20, 60);
    repeat (4100) @(posedge clk);
    check(code2, CODE_RESET);
    for (int b = 0; b < CODE_W; b++)
      bit2((5'h12 >> b) & 1 ? 30 : 31, (5'h12 >> b) & 1 ? 31 : 30);
    bit2(20, 10);
    check(code2, 5'h12);
    $display("broken word test done");
    results();
  end
endmodule : single_wire_brightness_rx_test
